//--- flash_host_pkg.sv
// Shared constants, types and helpers for the serial flash host controller.
package flash_host_pkg;

    // ********************************************************************
    // Clock and timing
    // ********************************************************************
    localparam int CLK_MHZ       = 20;
    localparam int T_CSS_NS      = 250;
    localparam int T_CSH_NS      = 250;
    localparam int T_CS_NS       = 250;
    localparam int T_CSB_NS      = 200;
    localparam int T_BRBD_NS     = 1000;
    localparam int T_RST_NS      = 10000;
    localparam int T_REC_NS      = 1000;
    localparam int T_PWR_US      = 20000;
    localparam int F_SCK_CAR_MHZ = 10;
    // Least times round up to whole cycles.
    localparam int CSS_CYC  = (T_CSS_NS * CLK_MHZ + 999) / 1000;
    localparam int CSH_CYC  = (T_CSH_NS * CLK_MHZ + 999) / 1000;
    localparam int CS_CYC   = (T_CS_NS * CLK_MHZ + 999) / 1000;
    localparam int CSB_CYC  = (T_CSB_NS * CLK_MHZ + 999) / 1000;
    localparam int BRBD_CYC = (T_BRBD_NS * CLK_MHZ + 999) / 1000;
    localparam int RST_CYC  = (T_RST_NS * CLK_MHZ + 999) / 1000;
    localparam int REC_CYC  = (T_REC_NS * CLK_MHZ + 999) / 1000;
    localparam int PWR_CYC  = T_PWR_US * CLK_MHZ;
    // Half period of the serial clock; at least the read limit and two for the sync delay.
    localparam int SCK_HALF_MIN = (CLK_MHZ + 2 * F_SCK_CAR_MHZ - 1) / (2 * F_SCK_CAR_MHZ);
    localparam int SCK_HALF_CYC = (SCK_HALF_MIN > 2) ? SCK_HALF_MIN : 2;
    localparam int PAGE_BYTES   = 264;
    localparam int CNT_W        = 20;

    // ********************************************************************
    // Opcodes
    // ********************************************************************
    localparam logic [7:0] OP_CONT_POL  = 8'h68;
    localparam logic [7:0] OP_CONT_SPI  = 8'he8;
    localparam logic [7:0] OP_PAGE_POL  = 8'h52;
    localparam logic [7:0] OP_PAGE_SPI  = 8'hd2;
    localparam logic [7:0] OP_BUF1_POL  = 8'h54;
    localparam logic [7:0] OP_BUF2_POL  = 8'h56;
    localparam logic [7:0] OP_BUF1_SPI  = 8'hd4;
    localparam logic [7:0] OP_BUF2_SPI  = 8'hd6;
    localparam logic [7:0] OP_STAT_POL  = 8'h57;
    localparam logic [7:0] OP_STAT_SPI  = 8'hd7;
    localparam logic [7:0] OP_XFER_BUF1 = 8'h53;
    localparam logic [7:0] OP_XFER_BUF2 = 8'h55;
    localparam logic [7:0] OP_CMP_BUF1  = 8'h60;
    localparam logic [7:0] OP_CMP_BUF2  = 8'h61;
    localparam logic [2:0] DUMMY_ARRAY  = 3'h4;
    localparam logic [2:0] DUMMY_BUFFER = 3'h1;
    localparam logic [2:0] ADDR_BYTES   = 3'h3;

    // ********************************************************************
    // Types
    // ********************************************************************
    typedef enum logic [2:0] {
        CMD_CONT_READ  = 3'h0,
        CMD_BURST_READ = 3'h1,
        CMD_PAGE_READ  = 3'h2,
        CMD_BUF_READ   = 3'h3,
        CMD_STATUS     = 3'h4,
        CMD_TRANSFER   = 3'h5,
        CMD_COMPARE    = 3'h6
    } cmd_t;

    // Bit 1 set selects the SPI-compatible opcodes, bit 0 set idles the clock high.
    typedef enum logic [1:0] {
        MODE_POL_LOW  = 2'h0,
        MODE_POL_HIGH = 2'h1,
        MODE_SPI0     = 2'h2,
        MODE_SPI3     = 2'h3
    } mode_t;

    typedef struct packed {
        cmd_t         cmd;
        logic         buf_sel;
        logic [10:0]  page;
        logic [8:0]   col;
        logic [15:0]  count;
    } req_t;

    // ********************************************************************
    // Helpers
    // ********************************************************************
    function automatic logic [7:0] opcode_of(input cmd_t c, input logic b, input mode_t m);
        logic spi;
        spi = m[1];
        case (c)
            CMD_CONT_READ, CMD_BURST_READ: opcode_of = spi ? OP_CONT_SPI : OP_CONT_POL;
            CMD_PAGE_READ: opcode_of = spi ? OP_PAGE_SPI : OP_PAGE_POL;
            CMD_BUF_READ: opcode_of = spi ? (b ? OP_BUF2_SPI : OP_BUF1_SPI)
                                          : (b ? OP_BUF2_POL : OP_BUF1_POL);
            CMD_STATUS: opcode_of = spi ? OP_STAT_SPI : OP_STAT_POL;
            CMD_TRANSFER: opcode_of = b ? OP_XFER_BUF2 : OP_XFER_BUF1;
            default: opcode_of = b ? OP_CMP_BUF2 : OP_CMP_BUF1;
        endcase
    endfunction

    // Opcode, address and don't-care bytes that precede the data.
    function automatic logic [2:0] header_len(input cmd_t c);
        case (c)
            CMD_STATUS: header_len = 3'h1;
            CMD_BUF_READ: header_len = 3'h1 + ADDR_BYTES + DUMMY_BUFFER;
            CMD_TRANSFER, CMD_COMPARE: header_len = 3'h1 + ADDR_BYTES;
            default: header_len = 3'h1 + ADDR_BYTES + DUMMY_ARRAY;
        endcase
    endfunction

    function automatic logic is_internal(input cmd_t c);
        is_internal = (c == CMD_TRANSFER) || (c == CMD_COMPARE);
    endfunction

endpackage

//--- flash_byte_shifter.sv
// Serial clock generator and one-byte shifter toward the flash pins.
`timescale 1ns/1ps
module flash_byte_shifter
    import flash_host_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_start,
    input  wire logic [7:0] i_tx_byte,
    input  wire logic       i_idle_high,
    input  wire logic       i_miso,
    output logic            o_sck,
    output logic            o_mosi,
    output logic [7:0]      o_rx_byte,
    output logic            o_done
);
    import flash_host_pkg::*;

    // ********************************************************************
    // State
    // ********************************************************************
    logic       active, next_active;
    logic       high, next_high;
    logic [3:0] cnt, next_cnt;
    logic [2:0] bitn, next_bitn;
    logic [7:0] tx_sh, next_tx_sh;
    logic [7:0] rx_sh, next_rx_sh;
    logic       sck, next_sck;
    logic       mosi, next_mosi;
    logic       done, next_done;
    logic       miso_s1, miso_s2;

    // Two-flop synchroniser on the returning data pin.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            miso_s1 <= 1'b0;
            miso_s2 <= 1'b0;
        end else begin
            miso_s1 <= i_miso;
            miso_s2 <= miso_s1;
        end
    end

    // Each bit is a low phase then a high phase; data moves on the fall, the flash samples on the rise.
    always_comb begin
        next_active = active;
        next_high   = high;
        next_cnt    = cnt;
        next_bitn   = bitn;
        next_tx_sh  = tx_sh;
        next_rx_sh  = rx_sh;
        next_sck    = sck;
        next_mosi   = mosi;
        next_done   = 1'b0;
        if (!active) begin
            next_sck = i_idle_high;
            if (i_start) begin
                next_active = 1'b1;
                next_high   = 1'b0;
                next_cnt    = 4'h0;
                next_bitn   = 3'h0;
                next_tx_sh  = i_tx_byte;
                next_mosi   = i_tx_byte[7];
                next_sck    = 1'b0;
            end
        end else if (cnt == 4'(SCK_HALF_CYC - 1)) begin
            next_cnt = 4'h0;
            if (!high) begin
                next_high = 1'b1;
                next_sck  = 1'b1;
            end else begin
                // Read the returned bit just before the next falling edge.
                next_rx_sh = {rx_sh[6:0], miso_s2};
                if (bitn == 3'h7) begin
                    next_active = 1'b0;
                    next_done   = 1'b1;
                    next_sck    = i_idle_high;
                end else begin
                    next_bitn  = bitn + 3'h1;
                    next_high  = 1'b0;
                    next_sck   = 1'b0;
                    next_tx_sh = {tx_sh[6:0], 1'b0};
                    next_mosi  = tx_sh[6];
                end
            end
        end else begin
            next_cnt = cnt + 4'h1;
        end
    end

    // Registers of the shifter.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            active <= 1'b0;
            high   <= 1'b0;
            cnt    <= 4'h0;
            bitn   <= 3'h0;
            tx_sh  <= 8'h00;
            rx_sh  <= 8'h00;
            sck    <= 1'b0;
            mosi   <= 1'b0;
            done   <= 1'b0;
        end else begin
            active <= next_active;
            high   <= next_high;
            cnt    <= next_cnt;
            bitn   <= next_bitn;
            tx_sh  <= next_tx_sh;
            rx_sh  <= next_rx_sh;
            sck    <= next_sck;
            mosi   <= next_mosi;
            done   <= next_done;
        end
    end

    // Outputs come straight from flip-flops.
    assign o_sck     = sck;
    assign o_mosi    = mosi;
    assign o_rx_byte = rx_sh;
    assign o_done    = done;

endmodule // flash_byte_shifter

//--- flash_host_ctrl.sv
// Host controller that sequences read and internal commands to a serial flash.
//
// Overview of operation
// - A command may start with the clock idling low or high.
// - Continuous and burst array reads use 68H, or E8H in SPI modes.
// - Main memory page read uses 52H, or D2H in SPI modes.
// - Buffer read uses 54H or 56H, or D4H or D6H in SPI modes.
// - Status read uses 57H, or D7H in SPI modes, with no address.
// - Continuous read clock at most 10 MHz, others at most 15 MHz.
// - Burst read pauses at least 1 us at each page boundary.
// - Select is held high before the flash reset is released.
// - Reserved high address bits are sent as zero.
// - Every field moves in whole bytes of exactly eight clocks.
// - Wait 20 ms after power-up before the first command.
// - Commands marked for any mode work in all four clock modes.
`timescale 1ns/1ps
module flash_host_ctrl
    import flash_host_pkg::*;
#(
    parameter int POWER_UP_CYC = PWR_CYC
) (
    input  wire logic                   i_clk,
    input  wire logic                   i_rst_n,
    input  wire flash_host_pkg::mode_t  i_mode,
    input  wire flash_host_pkg::req_t   i_req,
    input  wire logic                   i_req_valid,
    output logic                        o_req_ready,
    output logic [7:0]                  o_rd_data,
    output logic                        o_rd_valid,
    output logic                        o_done,
    output logic                        o_busy,
    output logic                        o_cs_n,
    output logic                        o_sck,
    output logic                        o_mosi,
    output logic                        o_flash_rst_n,
    input  wire logic                   i_miso,
    input  wire logic                   i_rdy
);
    import flash_host_pkg::*;

    // ********************************************************************
    // Declarations
    // ********************************************************************
    typedef enum logic [3:0] {
        ST_POWER   = 4'h0,
        ST_RECOVER = 4'h1,
        ST_IDLE    = 4'h3,
        ST_SETUP   = 4'h2,
        ST_SHIFT   = 4'h6,
        ST_PAUSE   = 4'h7,
        ST_HOLD    = 4'h5,
        ST_CSHIGH  = 4'h4,
        ST_WAIT    = 4'hc
    } state_t;

    state_t             state, next_state;
    logic [CNT_W-1:0]   cnt, next_cnt;
    req_t               req, next_req;
    mode_t              mode, next_mode;
    logic [2:0]         pos, next_pos;
    logic               data_ph, next_data_ph;
    logic [15:0]        left, next_left;
    logic [8:0]         col, next_col;
    logic [7:0]         rd_data, next_rd_data;
    logic               rd_valid, next_rd_valid;
    logic               done, next_done;
    logic               cs_n, next_cs_n;
    logic               frst_n, next_frst_n;
    logic               start, next_start;
    logic [7:0]         tx, next_tx;
    logic               rdy_s1, rdy_s2;
    logic               eng_done;
    logic [7:0]         eng_rx;

    // Byte of the command header at a given position.
    function automatic logic [7:0] header_byte(input req_t r, input mode_t m,
                                               input logic [2:0] p);
        logic [10:0] pg;
        logic [8:0]  cl;
        pg = (r.cmd == CMD_BUF_READ) ? 11'h000 : r.page;
        cl = is_internal(r.cmd) ? 9'h000 : r.col;
        case (p)
            3'h0: header_byte = opcode_of(r.cmd, r.buf_sel, m);
            3'h1: header_byte = {4'h0, pg[10:7]};
            3'h2: header_byte = {pg[6:0], cl[8]};
            3'h3: header_byte = cl[7:0];
            default: header_byte = 8'h00;
        endcase
    endfunction

    // Count-up helper: true on the last cycle of a wait of n cycles.
    function automatic logic elapsed(input logic [CNT_W-1:0] c, input int n);
        elapsed = (c >= CNT_W'(n - 1));
    endfunction

    // ********************************************************************
    // Pin synchroniser and byte engine
    // ********************************************************************
    // Two-flop synchroniser on the ready/busy pin.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdy_s1 <= 1'b0;
            rdy_s2 <= 1'b0;
        end else begin
            rdy_s1 <= i_rdy;
            rdy_s2 <= rdy_s1;
        end
    end

    // Serial clock runs at a fixed divide well under the continuous read limit.
    flash_byte_shifter u_shifter (
        .i_clk       (i_clk),
        .i_rst_n     (i_rst_n),
        .i_start     (start),
        .i_tx_byte   (tx),
        .i_idle_high (mode[0]),
        .i_miso      (i_miso),
        .o_sck       (o_sck),
        .o_mosi      (o_mosi),
        .o_rx_byte   (eng_rx),
        .o_done      (eng_done)
    );

    // ********************************************************************
    // Command sequencer
    // ********************************************************************
    // Next-state logic for power-up, framing, header, data and busy wait.
    always_comb begin
        next_state    = state;
        next_cnt      = cnt;
        next_req      = req;
        next_mode     = mode;
        next_pos      = pos;
        next_data_ph  = data_ph;
        next_left     = left;
        next_col      = col;
        next_rd_data  = rd_data;
        next_rd_valid = 1'b0;
        next_done     = 1'b0;
        next_cs_n     = cs_n;
        next_frst_n   = frst_n;
        next_start    = 1'b0;
        next_tx       = tx;
        case (state)
            ST_POWER: begin
                // Reset held low with select high through the power-up wait.
                next_cs_n   = 1'b1;
                next_frst_n = 1'b0;
                next_cnt    = cnt + CNT_W'(1);
                if (elapsed(cnt, POWER_UP_CYC) && elapsed(cnt, RST_CYC)) begin
                    next_frst_n = 1'b1;
                    next_cnt    = '0;
                    next_state  = ST_RECOVER;
                end
            end
            ST_RECOVER: begin
                next_cnt = cnt + CNT_W'(1);
                if (elapsed(cnt, REC_CYC)) begin
                    next_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (i_req_valid && rdy_s2) begin
                    next_req     = i_req;
                    next_mode    = i_mode;
                    next_pos     = 3'h0;
                    next_data_ph = 1'b0;
                    next_left    = i_req.count;
                    next_col     = i_req.col;
                    next_cnt     = '0;
                    next_state   = ST_SETUP;
                end
            end
            ST_SETUP: begin
                // Select falls only once the clock sits at the new mode's idle level.
                next_cnt = cnt + CNT_W'(1);
                if (elapsed(cnt, 2)) begin
                    next_cs_n = 1'b0;
                end
                if (elapsed(cnt, CSS_CYC + 2)) begin
                    next_tx    = header_byte(req, mode, 3'h0);
                    next_start = 1'b1;
                    next_state = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (eng_done && !data_ph) begin
                    if (pos == header_len(req.cmd) - 3'h1) begin
                        if (is_internal(req.cmd) || left == 16'h0000) begin
                            next_cnt   = '0;
                            next_state = ST_HOLD;
                        end else begin
                            next_data_ph = 1'b1;
                            next_tx      = 8'h00;
                            next_start   = 1'b1;
                        end
                    end else begin
                        next_pos   = pos + 3'h1;
                        next_tx    = header_byte(req, mode, pos + 3'h1);
                        next_start = 1'b1;
                    end
                end else if (eng_done) begin
                    next_rd_data  = eng_rx;
                    next_rd_valid = 1'b1;
                    next_left     = left - 16'h0001;
                    next_col      = (col == 9'(PAGE_BYTES - 1)) ? 9'h000 : col + 9'h001;
                    next_tx       = 8'h00;
                    next_cnt      = '0;
                    if (left == 16'h0001) begin
                        next_state = ST_HOLD;
                    end else if (req.cmd == CMD_BURST_READ && col == 9'(PAGE_BYTES - 1)) begin
                        next_state = ST_PAUSE;
                    end else begin
                        next_start = 1'b1;
                    end
                end
            end
            ST_PAUSE: begin
                // Clock stays parked while the flash crosses into the next page.
                next_cnt = cnt + CNT_W'(1);
                if (elapsed(cnt, BRBD_CYC)) begin
                    next_start = 1'b1;
                    next_state = ST_SHIFT;
                end
            end
            ST_HOLD: begin
                next_cnt = cnt + CNT_W'(1);
                if (elapsed(cnt, CSH_CYC)) begin
                    next_cs_n  = 1'b1;
                    next_cnt   = '0;
                    next_state = ST_CSHIGH;
                end
            end
            ST_CSHIGH: begin
                // The select-high time also covers the delay until busy shows.
                next_cnt = cnt + CNT_W'(1);
                if (elapsed(cnt, CS_CYC) && elapsed(cnt, CSB_CYC)) begin
                    if (is_internal(req.cmd)) begin
                        next_state = ST_WAIT;
                    end else begin
                        next_done  = 1'b1;
                        next_state = ST_IDLE;
                    end
                end
            end
            ST_WAIT: begin
                // Transfer or compare ends only when ready returns.
                if (rdy_s2) begin
                    next_done  = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_POWER;
                next_cnt   = '0;
            end
        endcase
    end

    // Registers of the sequencer.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state    <= ST_POWER;
            cnt      <= '0;
            req      <= '0;
            mode     <= MODE_POL_LOW;
            pos      <= 3'h0;
            data_ph  <= 1'b0;
            left     <= 16'h0000;
            col      <= 9'h000;
            rd_data  <= 8'h00;
            rd_valid <= 1'b0;
            done     <= 1'b0;
            cs_n     <= 1'b1;
            frst_n   <= 1'b0;
            start    <= 1'b0;
            tx       <= 8'h00;
        end else begin
            state    <= next_state;
            cnt      <= next_cnt;
            req      <= next_req;
            mode     <= next_mode;
            pos      <= next_pos;
            data_ph  <= next_data_ph;
            left     <= next_left;
            col      <= next_col;
            rd_data  <= next_rd_data;
            rd_valid <= next_rd_valid;
            done     <= next_done;
            cs_n     <= next_cs_n;
            frst_n   <= next_frst_n;
            start    <= next_start;
            tx       <= next_tx;
        end
    end

    // ********************************************************************
    // Outputs
    // ********************************************************************
    // Ready and busy are combinational; valid, done, data and pins come from flip-flops.
    assign o_req_ready   = (state == ST_IDLE) && rdy_s2;
    assign o_busy        = (state != ST_IDLE);
    assign o_rd_data     = rd_data;
    assign o_rd_valid    = rd_valid;
    assign o_done        = done;
    assign o_cs_n        = cs_n;
    assign o_flash_rst_n = frst_n;

endmodule // flash_host_ctrl

//--- flash_model.sv
// Behavioural serial flash that answers the host controller.
`timescale 1ns/1ps
module flash_model #(
    parameter int XFR_NS = 2000
) (
    input  wire logic i_cs_n,
    input  wire logic i_sck,
    input  wire logic i_mosi,
    output logic      o_miso,
    output logic      o_rdy
);
    logic [7:0] sh = 8'h00, op = 8'h00, adr = 8'h00, dout;
    int         bits = 0, frame_bits = 0;
    initial o_miso = 1'b0;
    initial o_rdy = 1'b1;
    // Select low opens a frame whatever the idle clock level.
    always @(negedge i_cs_n) bits = 0;
    // Input bits are taken on the rising clock edge only, eight to a byte.
    always @(posedge i_sck) if (!i_cs_n) begin
        sh = {sh[6:0], i_mosi};
        bits++;
        if (bits == 8) op = sh;
        if (bits == 16) adr = sh;
    end
    // Output bits change on the falling edge, most significant first.
    always @(negedge i_sck) if (!i_cs_n) begin
        dout = 8'h3c ^ 8'(bits / 8);
        o_miso <= dout[7 - bits % 8];
    end
    // A released output shows the inverse; internal commands pull ready low.
    always @(posedge i_cs_n) begin
        o_miso <= ~o_miso;
        frame_bits = bits;
        if ((op == 8'h53 || op == 8'h55 || op == 8'h60 || op == 8'h61) && bits == 32) begin
            #110 o_rdy = 1'b0;
            #(XFR_NS) o_rdy = 1'b1;
        end
    end
endmodule // flash_model

//--- flash_host_monitor.sv
// Port-level assertions for the serial flash host controller.
`timescale 1ns/1ps
module flash_host_monitor
    import flash_host_pkg::*;
(
    input wire logic                  i_clk,
    input wire logic                  i_rst_n,
    input wire flash_host_pkg::mode_t i_mode,
    input wire flash_host_pkg::req_t  i_req,
    input wire logic                  i_req_valid,
    input wire logic                  o_req_ready,
    input wire logic [7:0]            o_rd_data,
    input wire logic                  o_rd_valid,
    input wire logic                  o_done,
    input wire logic                  o_busy,
    input wire logic                  o_cs_n,
    input wire logic                  o_sck,
    input wire logic                  o_mosi,
    input wire logic                  o_flash_rst_n,
    input wire logic                  i_miso,
    input wire logic                  i_rdy
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    AST_CS_SETUP: assert property ($fell(o_cs_n) |-> $stable(o_sck) [*5])
        else $error("clock moved during select setup");
    AST_SCK_IDLE: assert property ($fell(o_cs_n) |-> ##4 o_sck == i_mode[0])
        else $error("clock idle level does not follow mode");
    AST_MOSI_SETUP: assert property ($rose(o_sck) |-> $stable(o_mosi))
        else $error("serial data changed on rising clock");
    AST_SCK_RATE: assert property (!o_cs_n && $changed(o_sck) |=> $stable(o_sck))
        else $error("serial clock phase shorter than two cycles");
    AST_BYTE_SPACING: assert property (o_rd_valid |=> !o_rd_valid [*8])
        else $error("read bytes too close");
    AST_RST_CS: assert property (!o_flash_rst_n |-> o_cs_n)
        else $error("select low while flash held in reset");
    AST_READY_SYNC: assert property (o_req_ready |-> $past(i_rdy, 2) && !o_busy)
        else $error("request ready while flash busy");
    AST_DONE_PULSE: assert property (o_done |=> !o_done)
        else $error("done longer than one cycle");
    AST_CS_HIGH: assert property ($rose(o_cs_n) |-> o_cs_n [*5])
        else $error("select high time too short");
endmodule // flash_host_monitor
bind flash_host_ctrl flash_host_monitor mon (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_mode(i_mode),
    .i_req(i_req), .i_req_valid(i_req_valid), .o_req_ready(o_req_ready), .o_rd_data(o_rd_data),
    .o_rd_valid(o_rd_valid), .o_done(o_done), .o_busy(o_busy), .o_cs_n(o_cs_n), .o_sck(o_sck),
    .o_mosi(o_mosi), .o_flash_rst_n(o_flash_rst_n), .i_miso(i_miso), .i_rdy(i_rdy));

//--- flash_host_ctrl_tb.sv
// Self-checking bench for the serial flash host controller.
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
module flash_host_ctrl_tb;
    import flash_host_pkg::*;
    logic       i_clk = 1'b0, i_rst_n = 1'b0, i_req_valid = 1'b0;
    mode_t      i_mode = MODE_POL_LOW;
    req_t       i_req = '0;
    logic       o_req_ready, o_rd_valid, o_done, o_busy, o_cs_n, o_sck, o_mosi, o_flash_rst_n;
    logic       miso, rdy;
    logic [7:0] o_rd_data;
    int         mismatches = 0, comparisons = 0, seed = 32'hc6ee, got, hd, gap;
    flash_host_ctrl #(.POWER_UP_CYC(300)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_mode(i_mode),
        .i_req(i_req), .i_req_valid(i_req_valid), .o_req_ready(o_req_ready),
        .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .o_done(o_done), .o_busy(o_busy),
        .o_cs_n(o_cs_n), .o_sck(o_sck), .o_mosi(o_mosi), .o_flash_rst_n(o_flash_rst_n),
        .i_miso(miso), .i_rdy(rdy));
    flash_model fm (.i_cs_n(o_cs_n), .i_sck(o_sck), .i_mosi(o_mosi), .o_miso(miso), .o_rdy(rdy));
    // SPI modes set the top opcode bit of every read command.
    function automatic logic [7:0] exp_op(input int c, input logic b, input logic [1:0] m);
        logic [7:0] p;
        case (c)
            0, 1: p = 8'h68;
            2: p = 8'h52;
            3: p = b ? 8'h56 : 8'h54;
            4: p = 8'h57;
            5: p = b ? 8'h55 : 8'h53;
            default: p = b ? 8'h61 : 8'h60;
        endcase
        return (m[1] && c < 5) ? (p | 8'h80) : p;
    endfunction
    // Issues one command, collects its bytes and checks what the flash saw.
    task automatic run(input int c, input logic [1:0] m, input logic [8:0] col, input int n);
        if (c > 4) n = 0; // Internal commands move no data.
        @(posedge i_clk);
        i_mode <= mode_t'(m);
        i_req <= '{cmd_t'(c), 1'($random(seed)), 11'($random(seed)), col, 16'(n)};
        i_req_valid <= 1'b1;
        do @(negedge i_clk); while (o_req_ready !== 1'b1);
        @(posedge i_clk);
        i_req_valid <= 1'b0;
        hd = c == 4 ? 1 : c == 3 ? 5 : c > 4 ? 4 : 8;
        got = 0;
        while (o_done !== 1'b1) begin
            @(negedge i_clk);
            gap++;
            if (o_rd_valid === 1'b1) begin
                `CHK("read byte", 8'h3c ^ 8'(hd + got), o_rd_data)
                if (c == 1 && got > 0 && (col + got) % 264 == 0)
                    `CHK("page pause", 1'b1, gap >= 52)
                got++;
                gap = 0;
            end
        end
        `CHK("busy at done", 1'b0, o_busy)
        `CHK("byte count", n, got)
        `CHK("opcode", exp_op(c, i_req.buf_sel, m), fm.op)
        `CHK("frame bits", 8 * (hd + n), fm.frame_bits)
        if (c != 4) `CHK("high address", (c == 3) ? 8'h00 : {4'h0, i_req.page[10:7]}, fm.adr)
        if (c > 4) `CHK("ready at done", 1'b1, rdy)
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial forever #25 i_clk = ~i_clk;
    // Cuts a hang short.
    initial begin
        repeat (40000) @(posedge i_clk);
        mismatches++;
        stop_test;
    end
    // Corner cases first, then every command in every mode at random addresses.
    initial begin
        repeat (4) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (300) begin @(negedge i_clk); `CHK("early ready", 1'b0, o_req_ready) end
        run(4, 2'h0, 9'h000, 1);
        run(1, 2'h2, 9'h106, 3);
        run(2, 2'h3, 9'h000, 0);
        for (int m = 0; m < 4; m++)
            for (int c = 0; c < 7; c++)
                run(c, m[1:0], 9'({$random(seed)} % 264), {$random(seed)} % 4);
        stop_test;
    end
endmodule // flash_host_ctrl_tb
